// *** sec_erase_pkg.sv ***
// Constants, types and register map of the security erase and freeze block
package sec_erase_pkg;

    // ***********************************************************************
    // Register offsets
    // ***********************************************************************
    localparam logic [7:0] OFF_CMD     = 8'h00;
    localparam logic [7:0] OFF_DEV     = 8'h04;
    localparam logic [7:0] OFF_STATUS  = 8'h08;
    localparam logic [7:0] OFF_ERROR   = 8'h0C;
    localparam logic [7:0] OFF_DATA    = 8'h10;
    localparam logic [7:0] OFF_CFG     = 8'h14;
    localparam logic [7:0] OFF_STATE   = 8'h18;
    localparam logic [7:0] OFF_PW_BASE = 8'h40;
    localparam logic [7:0] OFF_PW_LAST = 8'hBC;

    // ***********************************************************************
    // Opcodes and field positions
    // ***********************************************************************
    localparam logic [7:0] CMD_SET_PW  = 8'hF1;
    localparam logic [7:0] CMD_UNLOCK  = 8'hF2;
    localparam logic [7:0] CMD_PREPARE = 8'hF3;
    localparam logic [7:0] CMD_ERASE   = 8'hF4;
    localparam logic [7:0] CMD_FREEZE  = 8'hF5;

    localparam int ABRT_BIT   = 2;
    localparam int DEV_BIT    = 4;
    localparam int CTL_IDENT  = 0;
    localparam int CTL_MODE   = 1;
    localparam int CFG_SUPP   = 0;
    localparam int CFG_ENH    = 1;
    localparam int CFG_LOCK   = 2;

    // ***********************************************************************
    // Transfer layout and reset values
    // ***********************************************************************
    localparam logic [8:0] XFER_WORDS = 9'h100;
    localparam logic [8:0] PW_FIRST   = 9'h001;
    localparam logic [8:0] PW_LAST    = 9'h010;
    localparam logic [7:0] DEV_RST    = 8'h00;
    localparam logic [7:0] ERR_RST    = 8'h00;
    localparam logic [2:0] CFG_RST    = 3'h3;

    typedef struct packed {
        logic bsy;
        logic drdy;
        logic df;
        logic na4;
        logic drq;
        logic na2;
        logic na1;
        logic err;
    } status_t;

    localparam status_t STATUS_RST = 8'h40;

    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CHECK, ST_ERASE} state_t;

endpackage

// *** sec_erase_unit.sv ***
// Security erase-unit and freeze-lock command interpreter with Wishbone registers
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module sec_erase_unit
    import sec_erase_pkg::*;
#(
    parameter logic [7:0] DIS_PW_OPCODE = 8'hF6,
    parameter int         PW_WORDS      = 32
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             DEV_SEL,
    output logic             ERASE_REQ,
    output logic             ERASE_ENHANCED,
    input  wire logic        ERASE_DONE,
    input  wire logic        ERASE_FAIL,
    input  wire logic        FAULT_IN
);

    // ***********************************************************************
    // State
    // ***********************************************************************
    state_t      state_q;
    status_t     status_q;
    logic [7:0]  error_q;
    logic [7:0]  dev_q;
    logic [2:0]  cfg_q;
    logic        locked_q;
    logic        frozen_q;
    logic        prepared_q;
    logic [8:0]  word_cnt_q;
    logic [15:0] ctl_q;
    logic        mismatch_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic        erase_req_q;
    logic        erase_enh_q;
    logic [15:0] pw_mem [PW_WORDS];

    // ***********************************************************************
    // Bus decode
    // ***********************************************************************
    wire        bus_req   = WB_CYC_I & WB_STB_I;
    wire        wr_take   = bus_req & WB_WE_I & ack_q;
    wire        lane0     = WB_SEL_I[0];
    wire        lane01    = &WB_SEL_I[1:0];
    wire        hit_cmd   = WB_ADR_I == OFF_CMD;
    wire        hit_dev   = WB_ADR_I == OFF_DEV;
    wire        hit_data  = WB_ADR_I == OFF_DATA;
    wire        hit_cfg   = WB_ADR_I == OFF_CFG;
    wire        hit_pw    = (WB_ADR_I >= OFF_PW_BASE) && (WB_ADR_I <= OFF_PW_LAST);
    wire [4:0]  pw_widx   = 5'(WB_ADR_I[7:2] - OFF_PW_BASE[7:2]);
    // Commands wait for an idle device, so a stray write cannot freeze mid-transfer
    wire        cmd_wr    = wr_take & hit_cmd & lane0 & ~status_q.bsy & ~status_q.drq;
    wire        data_wr   = wr_take & hit_data & lane01 & status_q.drq;
    wire        pw_wr     = wr_take & hit_pw & lane01 & ~status_q.bsy;
    wire [7:0]  opcode    = WB_DAT_I[7:0];

    // Read mux; the password store never reads back
    wire [31:0] rd_mux =
        (WB_ADR_I == OFF_STATUS) ? {24'h0, status_q} :
        (WB_ADR_I == OFF_ERROR)  ? {24'h0, error_q} :
        hit_dev                  ? {24'h0, dev_q} :
        hit_cfg                  ? {29'h0, locked_q, cfg_q[1:0]} :
        (WB_ADR_I == OFF_STATE)  ? {29'h0, prepared_q, frozen_q, locked_q} :
        32'h0;

    // ***********************************************************************
    // Command classification
    // ***********************************************************************
    wire supported   = cfg_q[CFG_SUPP];
    wire enh_ok      = cfg_q[CFG_ENH];
    wire lock_change = (opcode == CMD_SET_PW) || (opcode == CMD_UNLOCK) ||
                       (opcode == DIS_PW_OPCODE) || (opcode == CMD_PREPARE) ||
                       (opcode == CMD_ERASE);
    wire is_sec      = lock_change || (opcode == CMD_FREEZE);
    // Abort before any data moves, so the host never fills DRQ for nothing
    wire early_abort = (is_sec & ~supported) |
                       (lock_change & frozen_q) |
                       ((opcode == CMD_ERASE) & ~prepared_q) |
                       ((opcode == CMD_FREEZE) & locked_q);

    // ***********************************************************************
    // Password compare during the data phase
    // ***********************************************************************
    wire        in_pw     = (word_cnt_q >= PW_FIRST) && (word_cnt_q <= PW_LAST);
    wire [4:0]  pw_ridx   = {ctl_q[CTL_IDENT], 4'(word_cnt_q - PW_FIRST)};
    wire        word_bad  = in_pw && (pw_mem[pw_ridx] != WB_DAT_I[15:0]);
    wire        last_word = word_cnt_q == 9'(XFER_WORDS - 9'h001);
    wire        chk_abort = mismatch_q |
                            (ctl_q[CTL_MODE] & ~enh_ok);

    // ***********************************************************************
    // Outcome encoding
    // ***********************************************************************
    function automatic status_t done_status(input logic abort, input logic fault);
        status_t s;
        s      = STATUS_RST;
        s.bsy  = 1'b0;
        s.drdy = 1'b1;
        s.drq  = 1'b0;
        s.df   = abort & fault;
        s.err  = abort;
        return s;
    endfunction

    function automatic logic [7:0] done_error(input logic abort);
        logic [7:0] e;
        e           = ERR_RST;
        e[ABRT_BIT] = abort;
        return e;
    endfunction

    // ***********************************************************************
    // Wishbone slave: answer one cycle after request, drop the cycle after
    // ***********************************************************************
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= bus_req & ~ack_q;
            rdata_q <= rd_mux;
        end
    end

    // ***********************************************************************
    // Plain software registers
    // ***********************************************************************
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dev_q <= DEV_RST;
            cfg_q <= CFG_RST;
        end else begin
            if (wr_take & hit_dev & lane0 & ~status_q.bsy) begin
                dev_q <= WB_DAT_I[7:0];
            end
            if (wr_take & hit_cfg & lane0 & ~status_q.bsy) begin
                cfg_q <= WB_DAT_I[2:0];
            end
        end
    end

    // Password store has no reset; contents come from software only
    always_ff @(posedge MCLK) begin
        if (pw_wr) begin
            pw_mem[pw_widx] <= WB_DAT_I[15:0];
        end
    end

    // ***********************************************************************
    // Lock, frozen and prepared flags
    // ***********************************************************************
    wire erase_ok   = (state_q == ST_ERASE) & ERASE_DONE & ~ERASE_FAIL;
    wire lock_set   = wr_take & hit_cfg & lane0 & ~status_q.bsy & WB_DAT_I[CFG_LOCK];
    wire freeze_ok  = cmd_wr & (opcode == CMD_FREEZE) & ~early_abort;
    wire prepare_ok = cmd_wr & (opcode == CMD_PREPARE) & ~early_abort;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            locked_q   <= 1'b0;
            frozen_q   <= 1'b0;
            prepared_q <= 1'b0;
        end else begin
            if (erase_ok) begin
                locked_q <= 1'b0;
            end else if (lock_set) begin
                locked_q <= 1'b1;
            end
            if (freeze_ok) begin
                frozen_q <= 1'b1;
            end
            if (cmd_wr) begin
                prepared_q <= prepare_ok;
            end
        end
    end

    // ***********************************************************************
    // Command sequencer
    // ***********************************************************************
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q     <= ST_IDLE;
            status_q    <= STATUS_RST;
            error_q     <= ERR_RST;
            word_cnt_q  <= 9'h000;
            ctl_q       <= 16'h0000;
            mismatch_q  <= 1'b0;
            erase_req_q <= 1'b0;
            erase_enh_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        if (early_abort) begin
                            status_q <= done_status(1'b1, FAULT_IN);
                            error_q  <= done_error(1'b1);
                        end else if (opcode == CMD_ERASE) begin
                            status_q     <= STATUS_RST;
                            status_q.bsy <= 1'b0;
                            status_q.drq <= 1'b1;
                            error_q      <= ERR_RST;
                            word_cnt_q   <= 9'h000;
                            mismatch_q   <= 1'b0;
                            state_q      <= ST_XFER;
                        end else begin
                            // Freeze, prepare and foreign commands finish at once
                            status_q <= done_status(1'b0, 1'b0);
                            error_q  <= done_error(1'b0);
                        end
                    end
                end
                ST_XFER: begin
                    if (data_wr) begin
                        word_cnt_q <= 9'(word_cnt_q + 9'h001);
                        if (word_cnt_q == 9'h000) begin
                            ctl_q <= WB_DAT_I[15:0];
                        end
                        if (word_bad) begin
                            mismatch_q <= 1'b1;
                        end
                        if (last_word) begin
                            status_q.drq <= 1'b0;
                            status_q.bsy <= 1'b1;
                            state_q      <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (chk_abort) begin
                        status_q <= done_status(1'b1, FAULT_IN);
                        error_q  <= done_error(1'b1);
                        state_q  <= ST_IDLE;
                    end else begin
                        erase_req_q <= 1'b1;
                        erase_enh_q <= ctl_q[CTL_MODE];
                        state_q     <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    // Media engine zero-fills or writes patterns incl. spare sectors
                    if (ERASE_DONE) begin
                        erase_req_q <= 1'b0;
                        status_q    <= done_status(ERASE_FAIL, FAULT_IN);
                        error_q     <= done_error(ERASE_FAIL);
                        state_q     <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ***********************************************************************
    // Outputs
    // ***********************************************************************
    assign WB_DAT_O       = rdata_q;
    assign WB_ACK_O       = ack_q;
    assign DEV_SEL        = dev_q[DEV_BIT];
    assign ERASE_REQ      = erase_req_q;
    assign ERASE_ENHANCED = erase_enh_q;

endmodule // sec_erase_unit

// *** sec_erase_unit_sva.sv ***
// Assertion checker for the security erase and freeze block
`timescale 1ns/1ps
module sec_erase_unit_sva
    import sec_erase_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        DEV_SEL,
    input wire logic        ERASE_REQ,
    input wire logic        ERASE_ENHANCED,
    input wire logic        ERASE_DONE,
    input wire logic        ERASE_FAIL,
    input wire logic        FAULT_IN
);
    // ***********************************************************************
    // Bus, status and erase handshake properties
    // ***********************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    wire rd_ack = WB_ACK_O && !WB_WE_I;
    property p_ack_answer; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_dev_sel;
        $changed(DEV_SEL) |-> $past(WB_ACK_O && WB_WE_I && WB_ADR_I == OFF_DEV)
            && DEV_SEL == $past(WB_DAT_I[DEV_BIT]);
    endproperty
    property p_req_end; ERASE_REQ && ERASE_DONE |=> !ERASE_REQ; endproperty
    property p_req_hold;
        ERASE_REQ && !ERASE_DONE |=> ERASE_REQ && $stable(ERASE_ENHANCED);
    endproperty
    property p_busy_read;
        rd_ack && WB_ADR_I == OFF_STATUS && $past(ERASE_REQ) |-> WB_DAT_O[7] && !WB_DAT_O[3];
    endproperty
    property p_err_read;
        rd_ack && WB_ADR_I == OFF_ERROR |-> (WB_DAT_O & ~(32'h1 << ABRT_BIT)) == 32'h0;
    endproperty
    property p_stat_rsvd; rd_ack && WB_ADR_I == OFF_STATUS |-> (WB_DAT_O & 32'hFFFFFF16) == 0;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_dev_sel: assert property (p_dev_sel) else $error("device select wrong");
    a_req_end: assert property (p_req_end) else $error("erase not ended");
    a_req_hold: assert property (p_req_hold) else $error("erase dropped");
    a_busy_read: assert property (p_busy_read) else $error("busy not shown");
    a_err_read: assert property (p_err_read) else $error("stray error bit");
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved set");
    c_fail: cover property (ERASE_REQ && ERASE_DONE && ERASE_FAIL);
    c_enh: cover property (ERASE_REQ && ERASE_ENHANCED);
    c_abort: cover property (rd_ack && WB_ADR_I == OFF_ERROR && WB_DAT_O[ABRT_BIT]);
endmodule // sec_erase_unit_sva

bind sec_erase_unit sec_erase_unit_sva u_sva (.MCLK(MCLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .DEV_SEL(DEV_SEL),
    .ERASE_REQ(ERASE_REQ), .ERASE_ENHANCED(ERASE_ENHANCED), .ERASE_DONE(ERASE_DONE),
    .ERASE_FAIL(ERASE_FAIL), .FAULT_IN(FAULT_IN));

// *** media_model.sv ***
// Media partner model that finishes or fails an overwrite request
`timescale 1ns/1ps
module media_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       req,
    input  wire logic [3:0] dly,
    input  wire logic       bad,
    output logic            done,
    output logic            fail
);
    // ***********************************************************************
    // Overwrite timing
    // ***********************************************************************
    logic [3:0] cnt_q;
    logic       tog_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            tog_q <= 1'b0;
            done  <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            cnt_q <= (req && !done) ? cnt_q + 4'h1 : 4'h0;
            done  <= req && !done && cnt_q == dly;
        end
    end
    // Flag means nothing outside the pulse, so it wanders
    assign fail = done ? bad : tog_q;
endmodule // media_model

// *** sec_erase_unit_test.sv ***
// Self-checking bench for the security erase and freeze block
`timescale 1ns/1ps
module sec_erase_unit_test import sec_erase_pkg::*;;
    // ***********************************************************************
    // Stimulus, tasks and sequence
    // ***********************************************************************
    logic        mclk, rst_n, cyc, stb, we, fault, bad, ack, dev_sel, req, enh, done, efail;
    logic        req_seen, enh_seen;
    logic [3:0]  dly, sel, lanes;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  ops [5] = '{CMD_SET_PW, CMD_UNLOCK, 8'hF6, CMD_PREPARE, CMD_ERASE};
    int          err_count, compares;
    sec_erase_unit dut (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .DEV_SEL(dev_sel), .ERASE_REQ(req), .ERASE_ENHANCED(enh), .ERASE_DONE(done),
        .ERASE_FAIL(efail), .FAULT_IN(fault));
    media_model u_media (.clk(mclk), .rst_n(rst_n), .req(req), .dly(dly), .bad(bad),
        .done(done), .fail(efail));
    always @(posedge mclk) if (req) begin
        req_seen <= 1'b1;
        enh_seen <= enh;
    end
    function automatic logic [15:0] pw(input logic b, input int i);
        return (b ? 16'hB000 : 16'hA000) + 16'(i);
    endfunction
    task automatic conclude;
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        sel  <= lanes;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            $display("Error at %0t: no bus answer", $time);
            err_count++;
            conclude();
        end
        @(posedge mclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task automatic cmd(input logic [7:0] c);
        wb(1'b1, OFF_CMD, {24'h0, c});
    endtask
    // DRDY stays set on abort just as on completion
    task automatic res(input logic ab, input logic df);
        rc(OFF_STATUS, 32'hE9, ab ? {25'h0, 1'b1, df, 5'h01} : 32'h40);
        rc(OFF_ERROR, 32'hFF, ab ? 32'h04 : 32'h00);
    endtask
    task automatic erase(input logic [15:0] ctl, input logic wrong);
        logic [15:0] d;
        int          n;
        req_seen <= 1'b0;
        cmd(CMD_PREPARE);
        cmd(CMD_ERASE);
        rc(OFF_STATUS, 32'h88, 32'h08);
        for (int k = 0; k < 256; k++) begin
            d = (k == 0) ? ctl : (k > 16) ? 16'h5A5A : pw(ctl[0], k) ^ {15'h0, wrong && k == 16};
            wb(1'b1, OFF_DATA, {16'h0, d});
        end
        n = 0;
        do begin
            wb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end while (q[7] !== 1'b0 && n < 60);
        chk({31'h0, q[7]}, 32'h0);
        if (q[7] !== 1'b0) begin
            conclude();
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rst_n, cyc, stb, we, fault, bad, req_seen, enh_seen} = 8'h00;
        {dly, sel, adr, wdat, err_count, compares} = '0;
        dly = 4'h9;
        lanes = 4'hF;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rc(OFF_STATUS, 32'hFF, 32'h40);
        rc(OFF_ERROR, 32'hFF, 32'h00);
        rc(OFF_CFG, 32'h07, 32'h03);
        rc(OFF_STATE, 32'h07, 32'h00);
        rc(8'h20, 32'hFFFFFFFF, 32'h0);
        for (int i = 1; i <= 16; i++) begin
            wb(1'b1, OFF_PW_BASE + 8'(4 * (i - 1)), {16'h0, pw(1'b0, i)});
            wb(1'b1, OFF_PW_BASE + 8'(4 * (i + 15)), {16'h0, pw(1'b1, i)});
        end
        wb(1'b1, OFF_DEV, 32'h10);
        chk({31'h0, dev_sel}, 32'h1);
        rc(OFF_DEV, 32'h10, 32'h10);
        lanes = 4'hE;
        wb(1'b1, OFF_DEV, 32'h0);
        lanes = 4'hF;
        chk({31'h0, dev_sel}, 32'h1);
        cmd(CMD_ERASE);
        res(1'b1, 1'b0);
        cmd(CMD_PREPARE);
        cmd(8'h00);
        cmd(CMD_ERASE);
        res(1'b1, 1'b0);
        wb(1'b1, OFF_CFG, 32'h7);
        cmd(CMD_FREEZE);
        res(1'b1, 1'b0);
        erase(16'h0000, 1'b0);
        res(1'b0, 1'b0);
        chk({30'h0, req_seen, enh_seen}, 32'h2);
        rc(OFF_STATE, 32'h01, 32'h0);
        erase(16'h0000, 1'b1);
        res(1'b1, 1'b0);
        wb(1'b1, OFF_CFG, 32'h1);
        erase(16'h0002, 1'b0);
        res(1'b1, 1'b0);
        wb(1'b1, OFF_CFG, 32'h3);
        {dly, bad, fault} <= 6'h03;
        erase(16'h0003, 1'b0);
        res(1'b1, 1'b1);
        chk({30'h0, req_seen, enh_seen}, 32'h3);
        {bad, fault} <= 2'b00;
        wb(1'b1, OFF_CFG, 32'h2);
        cmd(CMD_ERASE);
        res(1'b1, 1'b0);
        cmd(CMD_FREEZE);
        res(1'b1, 1'b0);
        wb(1'b1, OFF_CFG, 32'h3);
        cmd(CMD_FREEZE);
        res(1'b0, 1'b0);
        cmd(CMD_FREEZE);
        res(1'b0, 1'b0);
        rc(OFF_STATE, 32'h02, 32'h2);
        foreach (ops[i]) begin
            cmd(ops[i]);
            res(1'b1, 1'b0);
        end
        rst_n <= 1'b0;
        @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rc(OFF_STATE, 32'h07, 32'h0);
        conclude();
    end
endmodule // sec_erase_unit_test
